// file: src/flo_cfg.svh
`ifndef FLO_CFG_SVH
`define FLO_CFG_SVH
// ****************************************
// Flash geometry
// ****************************************
`define FLO_PAGE_LOG2     9      // 512-byte erase page
`define FLO_ROW_LOG2      6      // 64-byte row, 8 per page
`define FLO_SECT_BIG_LOG2 10     // 1024-byte sector, 8 KB array
`define FLO_SECT_SML_LOG2 9      // 512-byte sector, smaller arrays
`define FLO_BIG_FLASH     8192   // Array size using big sectors
`define FLO_OPT_ADDR0     13'h0000
`define FLO_OPT_ADDR1     13'h0001
// ****************************************
// Register offsets and fields
// ****************************************
`define FLO_REG_CTRL      12'h000
`define FLO_REG_ADDR      12'h004
`define FLO_REG_DATA      12'h008
`define FLO_REG_PROT      12'h00C
`define FLO_REG_STATUS    12'h010
`define FLO_CTRL_GO       0
`define FLO_CTRL_OP_LSB   1
`define FLO_ST_BUSY       0
`define FLO_ST_PERR       1
`define FLO_ST_LOADED     2
`define FLO_ST_PAGE_LSB   8
`define FLO_ST_ROW_LSB    12
`define FLO_ST_SECT_LSB   16
// ****************************************
// Option byte layout and reset values
// ****************************************
`define FLO_OPT_CKSEL_LSB 0      // Byte 0 bits 2:0
`define FLO_OPT_WDFD_BIT  3      // Byte 0 bit 3
`define FLO_OPT_TRIM_LSB  0      // Byte 1 bits 4:0
`define FLO_TRIM_RST      5'h0A
`define FLO_CKSEL_RST     3'h0
`define FLO_WDFD_RST      1'h0
`define FLO_PROT_RST      8'h00
`define FLO_LVL_MAX_MV    12'hE10
`define FLO_LVL_STEP_MV   12'h032
`define FLO_LVL_RST       12'hC1C
`endif

// file: src/flo_pkg.sv
package flo_pkg;
   // Loader states, Gray along load0, load1, run, cmd
   typedef enum logic [1:0] {
      FLO_LOAD0 = 2'h0,
      FLO_LOAD1 = 2'h1,
      FLO_RUN   = 2'h3,
      FLO_CMD   = 2'h2
   } flo_state_t;
   // Flash operations
   typedef enum logic [1:0] {
      FLO_OP_READ  = 2'h0,
      FLO_OP_PROG  = 2'h1,
      FLO_OP_ERASE = 2'h2
   } flo_op_t;
endpackage

// file: src/flo_flash_if.sv
`timescale 1ns/1ps
// Request path from the loader to the flash engine
interface flo_flash_if #(parameter int AW = 13);
   logic               start;  // One-cycle request
   flo_pkg::flo_op_t   op;
   logic [AW-1:0]      addr;
   logic [7:0]         wdata;
   logic               busy;   // Request outstanding
   logic               done;   // One-cycle completion
   logic [7:0]         rdata;
   modport ctl (output start, op, addr, wdata,
                input busy, done, rdata);
   modport eng (input start, op, addr, wdata,
                output busy, done, rdata);
endinterface

// file: src/flo_flash_geom.sv
`timescale 1ns/1ps
`include "flo_cfg.svh"
// Splits a flash byte address into page, row and sector
module flo_flash_geom #(
   parameter int FLASH_BYTES = 8192,
   parameter int AW          = 13
) (
   input  wire logic [AW-1:0] addr,
   output wire logic [3:0]    page,
   output wire logic [2:0]    row,
   output wire logic [2:0]    sector,
   output wire logic          is_opt
);
   localparam int SECT_LOG2 = (FLASH_BYTES == `FLO_BIG_FLASH) ?
                              `FLO_SECT_BIG_LOG2 : `FLO_SECT_SML_LOG2;
   wire logic [31:0] a32 = 32'(addr);
   // Page index, erase granule [R1]
   assign page   = 4'(a32 >> `FLO_PAGE_LOG2);
   // Row within page, eight rows of 64 bytes [R2]
   assign row    = 3'(a32 >> `FLO_ROW_LOG2);
   // Protection sector, size depends on array [R3]
   assign sector = 3'(a32 >> SECT_LOG2);
   // Two lowest bytes hold the option bytes [R4]
   assign is_opt = (addr == AW'(`FLO_OPT_ADDR0)) |
                   (addr == AW'(`FLO_OPT_ADDR1));
endmodule // flo_flash_geom

// file: src/flo_flash_port.sv
`timescale 1ns/1ps
// Drives the flash array handshake, one operation at a time
module flo_flash_port #(parameter int AW = 13) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   flo_flash_if.eng           fi,
   output wire logic          flash_req,
   output wire logic [1:0]    flash_op,
   output wire logic [AW-1:0] flash_addr,
   output wire logic [7:0]    flash_wdata,
   input  wire logic [7:0]    flash_rdata,
   input  wire logic          flash_ack
);
   logic          req_q;     // Request held until acknowledged
   logic [1:0]    op_q;
   logic [AW-1:0] addr_q;
   logic [7:0]    wdata_q;
   logic          done_q;
   logic [7:0]    rdata_q;
   wire logic take = fi.start & ~req_q;
   wire logic fin  = req_q & flash_ack;
   // Launch and retire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_q   <= 1'b0;
         op_q    <= 2'h0;
         addr_q  <= '0;
         wdata_q <= 8'h00;
         done_q  <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         req_q  <= take | (req_q & ~flash_ack);
         done_q <= fin;
         if (take) begin
            op_q    <= fi.op;
            addr_q  <= fi.addr;
            wdata_q <= fi.wdata;
         end
         if (fin) rdata_q <= flash_rdata;
      end
   end
   assign fi.busy     = req_q;
   assign fi.done     = done_q;
   assign fi.rdata    = rdata_q;
   assign flash_req   = req_q;
   assign flash_op    = op_q;
   assign flash_addr  = addr_q;
   assign flash_wdata = wdata_q;
endmodule // flo_flash_port

// file: src/flo_top.sv
`timescale 1ns/1ps
`include "flo_cfg.svh"
// ****************************************
// Operation
// R1 - 512-byte page is smallest erase unit
// R2 - Each page holds eight 64-byte rows
// R3 - Protect sectors 1024 bytes at 8K, else 512
// R4 - Two lowest flash bytes hold option bytes
// R5 - Every reset source reloads the option bytes
// R6 - Processor held in reset until loading completes
// R7 - Option byte changes apply only after reset
// R8 - Option registers invisible to software
// R9 - Trim lowers threshold 50 mV per step
// R10 - Enable bit switches watchdog oscillator fail detect
// R11 - Three-bit code selects system clock source
// R12 - Software never programs reserved clock codes
// ****************************************
module flo_top #(
   parameter int FLASH_BYTES = 8192,  // Array size in bytes
   parameter int AW          = $clog2(FLASH_BYTES)
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output wire logic [31:0]   prdata,
   output wire logic          pready,
   output wire logic          pslverr,
   input  wire logic          sys_reset_req,
   input  wire logic          stop_recovery,
   output wire logic          flash_req,
   output wire logic [1:0]    flash_op,
   output wire logic [AW-1:0] flash_addr,
   output wire logic [7:0]    flash_wdata,
   input  wire logic [7:0]    flash_rdata,
   input  wire logic          flash_ack,
   output wire logic          cpu_reset_n,
   output wire logic [2:0]    sysclk_source_select,
   output wire logic [4:0]    sysclk_src_onehot,
   output wire logic          sysclk_sel_reserved,
   output wire logic          wdog_osc_fail_detect_en,
   output wire logic [4:0]    low_voltage_threshold_trim,
   output wire logic [11:0]   low_voltage_threshold_level
);
   // ****************************************
   // State
   // ****************************************
   flo_pkg::flo_state_t state_q, state_d;  // Loader sequence
   logic          pend_q;      // Flash operation outstanding
   logic          reload_q;    // Reset seen, reload owed
   logic          cpu_rst_n_q; // Processor release
   logic          loaded_q;    // Options valid since reset
   logic [7:0]    stage0_q;    // First option byte, not yet live
   logic [2:0]    cksel_q;     // Live option configuration
   logic          wdfd_q;
   logic [4:0]    trim_q;
   logic [11:0]   lvl_q;       // Threshold in millivolts
   logic [AW-1:0] addr_q;      // Software flash address
   logic [7:0]    wdata_q;     // Byte to program
   logic [7:0]    rdbyte_q;    // Last byte read by software
   logic [7:0]    prot_q;      // Sector write protect mask
   logic          perr_q;      // Protected write refused
   logic [31:0]   prdata_q;
   logic          cmd_rd_q;    // Running command is a read

   flo_flash_if #(.AW(AW)) fi ();

   flo_flash_port #(.AW(AW)) u_port (
      .pclk        (pclk),
      .presetn     (presetn),
      .fi          (fi),
      .flash_req   (flash_req),
      .flash_op    (flash_op),
      .flash_addr  (flash_addr),
      .flash_wdata (flash_wdata),
      .flash_rdata (flash_rdata),
      .flash_ack   (flash_ack)
   );

   wire logic [3:0] g_page;
   wire logic [2:0] g_row;
   wire logic [2:0] g_sect;
   wire logic       g_opt;
   flo_flash_geom #(.FLASH_BYTES(FLASH_BYTES), .AW(AW)) u_geom (
      .addr   (addr_q),
      .page   (g_page),
      .row    (g_row),
      .sector (g_sect),
      .is_opt (g_opt)
   );

   // ****************************************
   // APB decode
   // ****************************************
   wire logic acc     = psel & penable;
   wire logic wr      = acc & pwrite;
   wire logic s_ctrl  = (paddr == `FLO_REG_CTRL);
   wire logic s_addr  = (paddr == `FLO_REG_ADDR);
   wire logic s_data  = (paddr == `FLO_REG_DATA);
   wire logic s_prot  = (paddr == `FLO_REG_PROT);
   wire logic s_stat  = (paddr == `FLO_REG_STATUS);
   // Option registers have no address at all [R8]
   wire logic hit     = s_ctrl | s_addr | s_data | s_prot | s_stat;
   wire logic [1:0] wop = pwdata[`FLO_CTRL_OP_LSB +: 2];
   // Commands are taken only while running and idle
   wire logic go      = wr & s_ctrl & pwdata[`FLO_CTRL_GO] &
                        (state_q == flo_pkg::FLO_RUN) &
                        ~reload_q & ~pend_q & (wop != 2'h3);
   // Writes and erases into a protected sector are refused [R3]
   wire logic blocked = (wop != 2'(flo_pkg::FLO_OP_READ)) &
                        prot_q[g_sect];
   wire logic cmd_go  = go & ~blocked;
   wire logic trig    = sys_reset_req | stop_recovery;
   wire logic in_ld   = (state_q == flo_pkg::FLO_LOAD0) |
                        (state_q == flo_pkg::FLO_LOAD1);
   // Loads fetch one byte at a time from the two lowest bytes
   wire logic ld_go   = in_ld & ~pend_q & ~reload_q;
   wire logic commit  = (state_q == flo_pkg::FLO_LOAD1) & fi.done &
                        ~reload_q & ~trig;

   // Erase address drops to page base, page is the granule [R1]
   wire logic [AW-1:0] page_base =
      {addr_q[AW-1:`FLO_PAGE_LOG2], {`FLO_PAGE_LOG2{1'b0}}};

   assign fi.start = ld_go | cmd_go;
   assign fi.op    = ld_go ? flo_pkg::FLO_OP_READ :
                     flo_pkg::flo_op_t'(wop);
   assign fi.addr  = ld_go ?
                     ((state_q == flo_pkg::FLO_LOAD0) ?
                      AW'(`FLO_OPT_ADDR0) : AW'(`FLO_OPT_ADDR1)) :
                     (wop == 2'(flo_pkg::FLO_OP_ERASE)) ?
                     page_base : addr_q;  // [R4] [R1]
   assign fi.wdata = wdata_q;

   // Read mux, option registers never appear here [R8]
   wire logic [31:0] st_word =
      (32'(g_sect) << `FLO_ST_SECT_LSB) |
      (32'(g_row) << `FLO_ST_ROW_LSB) |
      (32'(g_page) << `FLO_ST_PAGE_LSB) |
      (32'(loaded_q) << `FLO_ST_LOADED) |
      (32'(perr_q) << `FLO_ST_PERR) |
      (32'(pend_q) << `FLO_ST_BUSY);
   wire logic [31:0] rd_mux =
      s_addr ? 32'(addr_q) :
      s_data ? 32'(rdbyte_q) :
      s_prot ? 32'(prot_q) :
      s_stat ? st_word : 32'h0000_0000;

   // ****************************************
   // Loader sequence
   // ****************************************
   // Next state; a new reset restarts the load unless it comes as byte 0 completes [R5]
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         flo_pkg::FLO_LOAD0:
            if (fi.done) begin
               state_d = reload_q ? flo_pkg::FLO_LOAD0 :
                         flo_pkg::FLO_LOAD1;
            end
         flo_pkg::FLO_LOAD1:
            if (fi.done) begin
               state_d = commit ? flo_pkg::FLO_RUN :
                         flo_pkg::FLO_LOAD0;
            end
         flo_pkg::FLO_RUN:
            if (reload_q) begin
               state_d = flo_pkg::FLO_LOAD0;
            end else if (cmd_go) begin
               state_d = flo_pkg::FLO_CMD;
            end
         flo_pkg::FLO_CMD:
            if (fi.done) begin
               state_d = (reload_q | trig) ? flo_pkg::FLO_LOAD0 :
                         flo_pkg::FLO_RUN;
            end
      endcase
   end

   // Sequencing flags; a reset request wins over its own clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q     <= flo_pkg::FLO_LOAD0;
         pend_q      <= 1'b0;
         reload_q    <= 1'b0;
         cpu_rst_n_q <= 1'b0;
         loaded_q    <= 1'b0;
         cmd_rd_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         pend_q   <= fi.start | (pend_q & ~fi.done);
         // Cleared only once nothing is outstanding [R5]
         reload_q <= trig | (reload_q & pend_q);
         // Held low from any reset until options are live [R6]
         cpu_rst_n_q <= ~trig & (commit | cpu_rst_n_q);
         loaded_q    <= ~trig & (commit | loaded_q);
         if (cmd_go) cmd_rd_q <= (wop == 2'(flo_pkg::FLO_OP_READ));
      end
   end

   // Option bytes become live only at a completed load [R7]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage0_q <= 8'h00;
         cksel_q  <= `FLO_CKSEL_RST;
         wdfd_q   <= `FLO_WDFD_RST;
         trim_q   <= `FLO_TRIM_RST;
         lvl_q    <= `FLO_LVL_RST;
      end else begin
         if ((state_q == flo_pkg::FLO_LOAD0) & fi.done) begin
            stage0_q <= fi.rdata;
         end
         if (commit) begin
            cksel_q <= stage0_q[`FLO_OPT_CKSEL_LSB +: 3];  // [R11]
            wdfd_q  <= stage0_q[`FLO_OPT_WDFD_BIT];        // [R10]
            trim_q  <= fi.rdata[`FLO_OPT_TRIM_LSB +: 5];   // [R9]
            lvl_q   <= lvl_of(fi.rdata[`FLO_OPT_TRIM_LSB +: 5]);
         end
      end
   end

   // Not clamped: codes past the table keep falling linearly
   // Threshold drops one step per trim code from the maximum [R9]
   function automatic logic [11:0] lvl_of(input logic [4:0] t);
      logic [11:0] p;
      p = 12'(t) * `FLO_LVL_STEP_MV;
      return `FLO_LVL_MAX_MV - p;
   endfunction

   // ****************************************
   // Software registers
   // ****************************************
   // Address, data, protection and error flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q   <= '0;
         wdata_q  <= 8'h00;
         rdbyte_q <= 8'h00;
         prot_q   <= `FLO_PROT_RST;
         perr_q   <= 1'b0;
      end else begin
         if (wr & s_addr) addr_q <= pwdata[AW-1:0];
         if (wr & s_data) wdata_q <= pwdata[7:0];
         if (wr & s_prot) prot_q <= pwdata[7:0];
         if ((state_q == flo_pkg::FLO_CMD) & fi.done & cmd_rd_q) begin
            rdbyte_q <= fi.rdata;
         end
         // Refusal wins over a write-one clear [R3]
         perr_q <= (go & blocked) |
                   (perr_q & ~(wr & s_stat & pwdata[`FLO_ST_PERR]));
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= 32'h0000_0000;
      else if (psel & ~penable & ~pwrite) prdata_q <= rd_mux;
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;

   // ****************************************
   // Option outputs
   // ****************************************
   // Steering keeps a defined clock even for a bad code
   // Reserved codes flagged and steered to the internal source
   wire logic rsv = (cksel_q > 3'h4);  // [R11] [R12]
   wire logic [2:0] eff_sel = rsv ? `FLO_CKSEL_RST : cksel_q;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_src
         assign sysclk_src_onehot[gi] = (eff_sel == 3'(gi));  // [R11]
      end
   endgenerate

   assign cpu_reset_n                 = cpu_rst_n_q;
   assign sysclk_source_select        = cksel_q;
   assign sysclk_sel_reserved         = rsv;
   assign wdog_osc_fail_detect_en     = wdfd_q;  // [R10]
   assign low_voltage_threshold_trim  = trim_q;
   assign low_voltage_threshold_level = lvl_q;

   // ****************************************
   // Assertions
   // ****************************************
   // Checks sleep through reset; the loader restarts from scratch
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_load;
      (state_q == flo_pkg::FLO_LOAD1) && fi.done && !reload_q && !trig;
   endsequence

   a_erase_page_base: assert property ( // [R1]
      flash_req && flash_op == 2'(flo_pkg::FLO_OP_ERASE)
      |-> flash_addr[`FLO_PAGE_LOG2-1:0] == '0)
      else $error("erase not page aligned");
   a_row_in_page: assert property ( // [R2]
      (32'(g_row) << `FLO_ROW_LOG2) + 32'(addr_q[`FLO_ROW_LOG2-1:0])
      == 32'(addr_q[`FLO_PAGE_LOG2-1:0]))
      else $error("row decode wrong");
   a_prot_refuse: assert property ( // [R3]
      go && blocked |-> !fi.start ##1 perr_q)
      else $error("protected write not refused");
   a_opt_addr: assert property ( // [R4]
      fi.start && in_ld |-> fi.addr <= AW'(`FLO_OPT_ADDR1))
      else $error("load outside option bytes");
   a_trig_holds: assert property ( // [R5]
      trig |=> !cpu_reset_n ##[1:200] state_q == flo_pkg::FLO_LOAD0)
      else $error("reset did not restart load");
   a_cpu_release: assert property ( // [R6]
      $rose(cpu_reset_n) |-> $past(state_q) == flo_pkg::FLO_LOAD1
      && loaded_q)
      else $error("cpu left reset before load");
   a_cfg_frozen: assert property ( // [R7]
      !s_load |=> $stable(cksel_q) && $stable(trim_q) && $stable(wdfd_q))
      else $error("config changed outside load");
   a_no_opt_read: assert property ( // [R8]
      psel && !penable && !pwrite && !hit |=> prdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_lvl_step: assert property ( // [R9]
      32'(lvl_q) + 32'(trim_q) * 32'd50 == 32'd3600)
      else $error("threshold step wrong");
   a_wdfd_load: assert property ( // [R10]
      s_load |=> wdog_osc_fail_detect_en == $past(stage0_q[3]))
      else $error("fail detect not loaded");
   a_clk_onehot: assert property ( // [R11]
      $onehot(sysclk_src_onehot) &&
      (rsv || sysclk_src_onehot[cksel_q]))
      else $error("clock select decode wrong");
   // Programming the option bytes leaves live settings alone
   a_opt_prog_late: assert property ( // [R7]
      (state_q == flo_pkg::FLO_CMD) && fi.busy && g_opt
      |=> $stable(cksel_q) && $stable(wdfd_q) && $stable(trim_q))
      else $error("option write changed live config");
endmodule // flo_top

// file: tb/flo_flash_model.sv
`timescale 1ns/1ps
// ****************************************
// Flash array model, answers after lat cycles
// ****************************************
module flo_flash_model #(
   parameter int FLASH_BYTES = 8192,
   parameter int AW          = 13
) (
   input  wire logic          pclk,
   input  wire logic          flash_req,
   input  wire logic [1:0]    flash_op,
   input  wire logic [AW-1:0] flash_addr,
   input  wire logic [7:0]    flash_wdata,
   input  wire logic [3:0]    lat,
   output logic      [7:0]    flash_rdata = 8'h00,
   output logic               flash_ack   = 1'b0
);
   logic [7:0] mem [FLASH_BYTES];  // Array contents
   logic [3:0] cnt = 4'h0;         // Wait counter
   // One request at a time; ack is a single-cycle pulse
   always @(posedge pclk) begin
      flash_ack   <= 1'b0;
      // Read data not held: toggles so stale bytes never match
      flash_rdata <= ~flash_rdata;
      if (flash_req && !flash_ack) begin
         if (cnt < lat) begin
            cnt <= cnt + 4'h1;
         end else begin
            cnt       <= 4'h0;
            flash_ack <= 1'b1;
            case (flash_op)
               2'h0: flash_rdata <= mem[flash_addr];
               2'h1: mem[flash_addr] <= flash_wdata;
               2'h2: begin
                  // Whole 512-byte page cleared at once
                  for (int i = 0; i < 512; i++) begin
                     mem[{flash_addr[AW-1:9], 9'h000} + i] <= 8'hFF;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule // flo_flash_model

// file: tb/tb_flo_top.sv
`timescale 1ns/1ps
module tb_flo_top;
   // ****************************************
   // Signals
   // ****************************************
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e, sys_req = 1'b0, stop_rec = 1'b0;
   logic        freq, fack, rst_n, ckres, wdfd;
   logic [1:0]  fop;
   logic [12:0] faddr;
   logic [7:0]  fwd, frd;
   logic [3:0]  lat = 4'h1;
   logic [2:0]  cksel;
   logic [4:0]  onehot, trim;
   logic [11:0] level;
   int          errors = 0, n_compared = 0;
   always #5 pclk = ~pclk;
   flo_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_reset_req(sys_req), .stop_recovery(stop_rec),
      .flash_req(freq), .flash_op(fop), .flash_addr(faddr),
      .flash_wdata(fwd), .flash_rdata(frd), .flash_ack(fack),
      .cpu_reset_n(rst_n), .sysclk_source_select(cksel),
      .sysclk_src_onehot(onehot), .sysclk_sel_reserved(ckres),
      .wdog_osc_fail_detect_en(wdfd), .low_voltage_threshold_trim(trim),
      .low_voltage_threshold_level(level));
   flo_flash_model i_mem (.pclk(pclk), .flash_req(freq), .flash_op(fop),
      .flash_addr(faddr), .flash_wdata(fwd), .lat(lat),
      .flash_rdata(frd), .flash_ack(fack));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] g, x, input string m);
      n_compared++;
      if (g !== x) begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   // One APB transfer; holds until pready seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cycle count assumed; the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h010, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 50);
      chk(n < 50, 1, "command hang");
   endtask
   task automatic opts(input logic [2:0] c, input logic w,
                       input logic [4:0] t);
      chk(cksel, c, "clock code");
      chk(onehot, c < 5 ? 5'h01 << c : 5'h01, "onehot");
      chk(ckres, c > 4, "reserved");
      chk(wdfd, w, "fail detect");
      chk(trim, t, "trim");
      chk(level, 12'hE10 - 12'h032 * t, "level");
   endtask
   // Pulses one reset source, then waits for the reload
   task automatic trig(input logic stop);
      int n;
      @(posedge pclk);
      sys_req <= ~stop; stop_rec <= stop;
      @(posedge pclk);
      sys_req <= 1'b0; stop_rec <= 1'b0;
      @(posedge pclk);
      chk(rst_n, 0, "cpu not held");
      n = 0;
      while (rst_n !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(rst_n, 1, "reload hang");
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_codes();
      // Reserved clock codes are never put into flash
      for (int c = 0; c < 5; c++) begin
         i_mem.mem[0] = {4'h0, c[0], c[2:0]};
         i_mem.mem[1] = 8'(c * 4 + 2);
         lat <= 4'(c[1:0] * 3);
         trig(c[1]);
         opts(c[2:0], c[0], 5'(c * 4 + 2));
      end
      $display("codes done");
   endtask
   task automatic t_regs();
      apb(1'b0, 12'h020, 32'h0);
      chk(e, 1, "unmapped error");
      chk(q, 32'h0, "unmapped read");
      apb(1'b1, 12'h030, 32'hFFFF_FFFF);
      opts(3'h4, 1'b0, 5'h12);
      apb(1'b1, 12'h004, 32'hFFFF_FA40);
      apb(1'b0, 12'h004, 32'h0);
      chk(q, 32'h0000_1A40, "addr reg");
      apb(1'b0, 12'h010, 32'h0);
      chk(q, 32'h0006_1D04, "page row sector");
      $display("regs done");
   endtask
   task automatic t_prog();
      apb(1'b1, 12'h004, 32'h0);
      apb(1'b1, 12'h008, 32'h21);
      apb(1'b1, 12'h000, 32'h3);
      wait_idle();
      chk(i_mem.mem[0], 8'h21, "option programmed");
      apb(1'b1, 12'h000, 32'h1);
      wait_idle();
      apb(1'b0, 12'h008, 32'h0);
      chk(q, 32'h21, "read command");
      opts(3'h4, 1'b0, 5'h12);
      trig(1'b0);
      opts(3'h1, 1'b0, 5'h12);
      i_mem.mem[12'h840] = 8'h77;
      apb(1'b1, 12'h00C, 32'h4);
      apb(1'b1, 12'h004, 32'h840);
      apb(1'b1, 12'h000, 32'h3);
      wait_idle();
      chk(q[1], 1, "protect refused");
      chk(i_mem.mem[12'h840], 8'h77, "protected byte");
      $display("prog done");
   endtask
   task automatic t_erase();
      i_mem.mem[12'h1FF] = 8'h5A;
      i_mem.mem[12'h3FF] = 8'h11;
      i_mem.mem[12'h400] = 8'h22;
      apb(1'b1, 12'h00C, 32'h0);
      apb(1'b1, 12'h010, 32'h2);
      apb(1'b0, 12'h010, 32'h0);
      chk(q[1], 0, "perr clear");
      apb(1'b1, 12'h004, 32'h200);
      apb(1'b1, 12'h000, 32'h5);
      wait_idle();
      chk(i_mem.mem[12'h200], 8'hFF, "page start");
      chk(i_mem.mem[12'h3FF], 8'hFF, "page end");
      chk(i_mem.mem[12'h1FF], 8'h5A, "page below");
      chk(i_mem.mem[12'h400], 8'h22, "page above");
      $display("erase done");
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      i_mem.mem[0] = 8'h0B;
      i_mem.mem[1] = 8'h13;
      repeat (4) @(posedge pclk);
      opts(3'h0, 1'b0, 5'h0A);
      chk({rst_n, freq}, 2'b00, "held in reset");
      @(posedge pclk);
      presetn <= 1'b1;
      for (int n = 0; n < 400 && rst_n !== 1'b1; n++) begin
         @(posedge pclk);
      end
      chk(rst_n, 1, "first load hang");
      opts(3'h3, 1'b1, 5'h13);
      t_codes();
      t_regs();
      t_prog();
      t_erase();
      results();
   end
   initial begin
      #200us;
      errors++;
      results();
   end
endmodule // tb_flo_top
